/* File: verilog/dcp_pkg.sv */
// Constants and carrier types for downstream charge-port power control.
// Assumes a single 25 MHz core clock and a serial configuration loader.
package dcp_pkg;
   localparam int DCP_NUM_PORTS = 3;
   localparam logic [7:0] DCP_CHG_EN_ADDR = 8'hd0;
   localparam logic [7:0] DCP_CHG_DET_ADDR = 8'hd1;
   localparam logic [7:0] DCP_CHG_EN_RESET = 8'h00;
   localparam logic [7:0] DCP_CHG_DET_RESET = 8'h00;
   localparam int DCP_CHG_EN_LSB = 1;
   localparam int DCP_DET_VALID_BIT = 0;
   localparam int DCP_CLK_MHZ = 25;
   localparam int DCP_QUERY_ACK_NS = 80;
   localparam int DCP_QUERY_ACK_CYC = (DCP_QUERY_ACK_NS * DCP_CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dcp_cfg_req_t;

   typedef enum logic [2:0] {
      DCP_ST_CONFIG = 3'b001,
      DCP_ST_CHARGE = 3'b010,
      DCP_ST_HUB = 3'b100
   } dcp_state_t;
endpackage : dcp_pkg

/* File: verilog/dcp_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the inputs are quasi-static compared with the core clock.
`timescale 1ns/1ps
module dcp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
      if (!reset_n) begin
         meta_nxt = reset_val;
         sync_nxt = reset_val;
      end
   end

   always_ff @(posedge sys_clk) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
   end

   assign sync_out = sync_r;
endmodule : dcp_sync

/* File: verilog/dcp_port_power.sv */
// Downstream port power arbitration between charging logic and hub logic.
// Assumes a serial configuration loader on the core clock and hub-class
// port-power feature bits from the hub core; overcurrent pins are async.
`timescale 1ns/1ps
module dcp_port_power
   import dcp_pkg::*;
#(
   parameter int NUM_PORTS = DCP_NUM_PORTS
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire dcp_cfg_req_t cfg_req,
   input wire logic cfg_done,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic hub_enumerated,
   input wire logic [NUM_PORTS-1:0] hub_port_power_feature,
   input wire logic [NUM_PORTS-1:0] hub_port_power,
   input wire logic [NUM_PORTS-1:0] overcurrent_sense_n,
   input wire logic [NUM_PORTS-1:0] charge_query,
   output logic [NUM_PORTS-1:0] charge_query_ack,
   input wire logic charger_detect_valid,
   output logic [NUM_PORTS-1:0] port_power_out,
   output logic [NUM_PORTS-1:0] port_power_reg,
   output logic [NUM_PORTS-1:0] charge_mode
);
   initial begin
      if (NUM_PORTS < 1 || NUM_PORTS > 7) begin
         $error("dcp_port_power: NUM_PORTS must be 1 to 7");
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [NUM_PORTS-1:0] oc_n_sync;
   logic det_sync;

   dcp_sync #(.WIDTH(NUM_PORTS + 1)) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in({charger_detect_valid, overcurrent_sense_n}),
      .reset_val({1'b0, {NUM_PORTS{1'b1}}}),
      .sync_out({det_sync, oc_n_sync})
   );

   function automatic logic [NUM_PORTS-1:0] ports_of(input logic [7:0] reg_val);
      ports_of = reg_val[DCP_CHG_EN_LSB +: NUM_PORTS];
   endfunction : ports_of

   // ----------------------------------------------------------------
   // Configuration registers and phase
   // ----------------------------------------------------------------
   dcp_state_t state_r, state_nxt;
   logic [7:0] chg_en_r, chg_en_nxt;
   logic [7:0] chg_det_r, chg_det_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [NUM_PORTS-1:0] mode_r, mode_nxt;

   always_comb begin
      state_nxt = state_r;
      chg_en_nxt = chg_en_r;
      chg_det_nxt = chg_det_r;
      mode_nxt = mode_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      // Writes after configuration are stored but never change the role
      if (cfg_req.wr && cfg_req.addr == DCP_CHG_EN_ADDR) begin
         chg_en_nxt = cfg_req.wdata;
      end
      if (det_sync) begin
         chg_det_nxt[DCP_DET_VALID_BIT] = 1'b1;
      end else if (cfg_req.wr && cfg_req.addr == DCP_CHG_DET_ADDR) begin
         chg_det_nxt = DCP_CHG_DET_RESET;
      end
      if (cfg_req.rd) begin
         rvalid_nxt = 1'b1;
         unique case (cfg_req.addr)
            DCP_CHG_EN_ADDR: rdata_nxt = chg_en_r;
            DCP_CHG_DET_ADDR: rdata_nxt = chg_det_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
      unique case (state_r)
         DCP_ST_CONFIG: begin
            if (cfg_done) begin
               mode_nxt = ports_of(chg_en_nxt);
               state_nxt = DCP_ST_CHARGE;
            end
         end
         DCP_ST_CHARGE: begin
            if (hub_enumerated) begin
               state_nxt = DCP_ST_HUB;
            end
         end
         DCP_ST_HUB: begin
            state_nxt = DCP_ST_HUB;
         end
         default: state_nxt = DCP_ST_CONFIG;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_r <= DCP_ST_CONFIG;
         chg_en_r <= DCP_CHG_EN_RESET;
         chg_det_r <= DCP_CHG_DET_RESET;
         mode_r <= '0;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         chg_en_r <= chg_en_nxt;
         chg_det_r <= chg_det_nxt;
         mode_r <= mode_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Per-port power arbitration
   // ----------------------------------------------------------------
   logic [NUM_PORTS-1:0] oc_latch_r, oc_latch_nxt;
   logic [NUM_PORTS-1:0] chg_pwr_r, chg_pwr_nxt;
   logic [NUM_PORTS-1:0] pwr_r, pwr_nxt;
   logic [NUM_PORTS-1:0] ack_r, ack_nxt;
   logic [2:0] ack_cnt_r [NUM_PORTS];
   logic [2:0] ack_cnt_nxt [NUM_PORTS];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         logic hub_owns;
         always_comb begin
            // Charging logic loses ownership once enumerated and feature set
            hub_owns = !mode_r[gi] || (state_r == DCP_ST_HUB && hub_port_power_feature[gi]);
            oc_latch_nxt[gi] = oc_latch_r[gi] | !oc_n_sync[gi];
            chg_pwr_nxt[gi] = chg_pwr_r[gi];
            if (state_r == DCP_ST_CONFIG && state_nxt == DCP_ST_CHARGE) begin
               chg_pwr_nxt[gi] = mode_nxt[gi];
            end
            if (oc_latch_nxt[gi]) begin
               chg_pwr_nxt[gi] = 1'b0;
            end
            if (hub_owns) begin
               pwr_nxt[gi] = hub_port_power[gi];
            end else begin
               pwr_nxt[gi] = chg_pwr_nxt[gi];
            end
            if (!oc_n_sync[gi] || (mode_r[gi] && oc_latch_nxt[gi] && !hub_owns)) begin
               pwr_nxt[gi] = 1'b0;
            end
            ack_cnt_nxt[gi] = ack_cnt_r[gi];
            ack_nxt[gi] = 1'b0;
            if (ack_cnt_r[gi] != 3'h0) begin
               ack_cnt_nxt[gi] = ack_cnt_r[gi] - 3'h1;
               ack_nxt[gi] = 1'b1;
            end else if (charge_query[gi] && mode_r[gi] && state_r != DCP_ST_CONFIG) begin
               ack_cnt_nxt[gi] = 3'(DCP_QUERY_ACK_CYC - 1);
               ack_nxt[gi] = 1'b1;
            end
         end

         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               ack_cnt_r[gi] <= 3'h0;
            end else begin
               ack_cnt_r[gi] <= ack_cnt_nxt[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         oc_latch_r <= '0;
         chg_pwr_r <= '0;
         pwr_r <= '0;
         ack_r <= '0;
      end else begin
         oc_latch_r <= oc_latch_nxt;
         chg_pwr_r <= chg_pwr_nxt;
         pwr_r <= pwr_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign port_power_out = pwr_r;
   assign port_power_reg = pwr_r;
   assign charge_mode = mode_r;
   assign charge_query_ack = ack_r;
   assign cfg_rdata = rdata_r;
   assign cfg_rvalid = rvalid_r;
endmodule : dcp_port_power

/* File: dv/dcp_partner.sv */
// Model of the attached devices and their power switches.
// Assumes the bench says which loads short and which devices ask to charge.
`timescale 1ns/1ps
module dcp_partner (
   input wire logic sys_clk,
   input wire logic [2:0] short_req,
   input wire logic [2:0] want_req,
   input wire logic [2:0] charge_query_ack,
   output logic [2:0] overcurrent_sense_n,
   output logic [2:0] charge_query
);
   initial overcurrent_sense_n = 3'h7;
   initial charge_query = 3'h0;
   // A shorted load holds the switch flag low for as long as the fault lasts
   always @(negedge sys_clk) begin
      overcurrent_sense_n <= ~short_req;
      charge_query <= want_req & ~charge_query_ack;
   end
endmodule : dcp_partner

/* File: dv/dcp_port_power_props.sv */
// Checker for port power arbitration, bound to the top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dcp_port_power_props
   import dcp_pkg::*;
#(parameter int NUM_PORTS = DCP_NUM_PORTS) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire dcp_cfg_req_t cfg_req,
   input wire logic cfg_done,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic hub_enumerated,
   input wire logic [NUM_PORTS-1:0] hub_port_power_feature,
   input wire logic [NUM_PORTS-1:0] hub_port_power,
   input wire logic [NUM_PORTS-1:0] overcurrent_sense_n,
   input wire logic [NUM_PORTS-1:0] charge_query,
   input wire logic [NUM_PORTS-1:0] charge_query_ack,
   input wire logic [NUM_PORTS-1:0] port_power_out,
   input wire logic [NUM_PORTS-1:0] charge_mode
);
   logic done_r, done_nxt;
   logic enum_r;
   logic [7:0] en_r, en_nxt;
   logic [NUM_PORTS-1:0] cm;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   always_comb begin
      done_nxt = done_r | cfg_done;
      en_nxt = (cfg_req.wr && cfg_req.addr == DCP_CHG_EN_ADDR) ? cfg_req.wdata : en_r;
   end
   always_ff @(posedge sys_clk) begin
      done_r <= reset_n & done_nxt;
      // Hand-over to the hub takes effect one edge after enumeration is seen
      enum_r <= reset_n & (enum_r | hub_enumerated);
      en_r <= reset_n ? en_nxt : DCP_CHG_EN_RESET;
   end
   // Ports whose power the charging logic owns
   assign cm = charge_mode & ~(hub_port_power_feature & {NUM_PORTS{enum_r}});
   a_rd_enable: assert property (cfg_req.rd && cfg_req.addr == DCP_CHG_EN_ADDR |=> cfg_rvalid && cfg_rdata == en_r)
      else $error("enable register read wrong");
   a_rd_unmapped: assert property (cfg_req.rd && cfg_req.addr != DCP_CHG_EN_ADDR && cfg_req.addr != DCP_CHG_DET_ADDR
      |=> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_role_fixed: assert property (done_r && $past(done_r) |-> $stable(charge_mode)) else $error("role changed");
   a_cfg_load: assert property (cfg_done && !done_r |=> charge_mode == en_r[NUM_PORTS:1])
      else $error("role not loaded");
   a_oc_off: assert property ((port_power_out & ~overcurrent_sense_n & ~$past(overcurrent_sense_n)
      & ~$past(overcurrent_sense_n, 2) & ~$past(overcurrent_sense_n, 3)) == '0) else $error("power kept on fault");
   a_ack_cause: assert property ((charge_query_ack & ~$past(charge_query_ack)
      & ~($past(charge_query) & charge_mode)) == '0) else $error("ack without query");
   a_ack_width: assert property ($rose(charge_query_ack[0]) |=> charge_query_ack[0]) else $error("ack too short");
   a_hub_owner: assert property ((port_power_out & ~$past(cm) & ~$past(hub_port_power)) == '0)
      else $error("hub-owned power without request");
   a_chg_owner: assert property ((port_power_out & ~$past(port_power_out) & $past(cm)
      & $past(cm, 2) & $past(cm, 3)) == '0) else $error("charging power came back");
   c_cfg: cover property (cfg_done && !done_r);
   c_ack: cover property ($rose(charge_query_ack[0]));
   c_oc: cover property (|(~overcurrent_sense_n & cm));
endmodule : dcp_port_power_props
bind dcp_port_power dcp_port_power_props #(.NUM_PORTS(NUM_PORTS)) dcp_port_power_props_i (.*);

/* File: dv/dcp_port_power_test.sv */
// Self-checking bench for downstream port power arbitration.
// Assumes dcp_partner stands for the attached devices and switches.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dcp_port_power_test
   import dcp_pkg::*;
;
   logic sys_clk = 1'b0, reset_n = 1'b0, cfg_done = 1'b0, hub_enumerated = 1'b0, charger_detect_valid = 1'b0;
   dcp_cfg_req_t cfg_req = '0;
   logic [2:0] hub_port_power_feature = 3'h0, hub_port_power = 3'h0, short_req = 3'h0, want_req = 3'h0;
   logic [2:0] overcurrent_sense_n, charge_query, charge_query_ack, port_power_out, port_power_reg, charge_mode;
   logic [2:0] ack_seen = 3'h0, m_mode = 3'h0, m_lat = 3'h0;
   logic [7:0] cfg_rdata;
   logic cfg_rvalid;
   int mismatches = 0, checked = 0, en;
   always #20 sys_clk = ~sys_clk;
   always @(negedge sys_clk) ack_seen <= ack_seen | charge_query_ack;
   dcp_port_power dcp_port_power_i (.*);
   dcp_partner dcp_partner_i (.*);
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cfg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge sys_clk);
      cfg_req <= '0;
   endtask : cfg
   // Hub-owned ports follow the hub request, charging-owned ones stay on unless latched off
   function automatic logic [2:0] model_pwr();
      logic [2:0] own;
      own = ~m_mode | (hub_port_power_feature & {3{hub_enumerated}});
      return ((own & hub_port_power) | (~own & ~m_lat)) & ~short_req;
   endfunction : model_pwr
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial begin
      #50us;
      mismatches++;
      end_of_test();
   end
   initial begin
      en = $urandom(76);
      repeat (12) @(negedge sys_clk);
      reset_n <= 1'b1;
      cfg(0, DCP_CHG_EN_ADDR, 8'h00);
      `CHK(cfg_rdata, DCP_CHG_EN_RESET)
      cfg(0, 8'h5a, 8'h00);
      `CHK({cfg_rvalid, cfg_rdata}, 9'h100)
      // Ports 1 and 3 charge, port 2 stays standard; bit 0 and upper bits are random
      en = ($urandom & 32'hf1) | 32'h0a;
      cfg(1, DCP_CHG_EN_ADDR, en[7:0]);
      cfg(0, DCP_CHG_EN_ADDR, 8'h00);
      `CHK(cfg_rdata, en[7:0])
      charger_detect_valid <= 1'b1;
      repeat (4) @(negedge sys_clk);
      cfg(0, DCP_CHG_DET_ADDR, 8'h00);
      `CHK(cfg_rdata[DCP_DET_VALID_BIT], 1'b1)
      $display("test registers done");
      want_req <= 3'h7;
      hub_port_power <= 3'($urandom);
      cfg_done <= 1'b1;
      m_mode = en[3:1];
      repeat (2) @(negedge sys_clk);
      `CHK(charge_mode, m_mode)
      `CHK(port_power_out, model_pwr())
      `CHK(port_power_reg, model_pwr())
      cfg(1, DCP_CHG_EN_ADDR, ~en[7:0]);
      repeat (3) @(negedge sys_clk);
      `CHK(charge_mode, m_mode)
      repeat (8) begin
         hub_port_power <= 3'($urandom);
         repeat (2) @(negedge sys_clk);
         `CHK(port_power_out, model_pwr())
      end
      $display("test configuration done");
      short_req <= 3'h3;
      m_lat = 3'h1;
      repeat (5) @(negedge sys_clk);
      `CHK(port_power_out, model_pwr())
      short_req <= 3'h0;
      hub_port_power <= 3'h7;
      repeat (5) @(negedge sys_clk);
      `CHK(port_power_out, model_pwr())
      $display("test overcurrent done");
      hub_enumerated <= 1'b1;
      repeat (8) begin
         hub_port_power_feature <= 3'($urandom);
         hub_port_power <= 3'($urandom);
         repeat (2) @(negedge sys_clk);
         `CHK(port_power_out, model_pwr())
      end
      `CHK(ack_seen, m_mode)
      $display("test enumeration done");
      end_of_test();
   end
endmodule : dcp_port_power_test
